/* File: inc/pml_pkg.sv */
// shared constants and carrier types for the phy management register bank
package pml_pkg;

    // management frame fields
    localparam int PML_PREAMBLE_ONES = 32;
    localparam logic [1:0] PML_OP_READ = 2'h2;
    localparam logic [1:0] PML_OP_WRITE = 2'h1;
    localparam int PML_HEAD_BITS = 12;
    localparam int PML_DATA_BITS = 16;

    // management register indices (phy_register_select)
    localparam logic [4:0] PML_REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] PML_REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] PML_REG_ID_HIGH = 5'h02;
    localparam logic [4:0] PML_REG_ID_LOW = 5'h03;
    localparam logic [4:0] PML_REG_AN_ADVERT = 5'h04;
    localparam logic [4:0] PML_REG_LP_ABILITY = 5'h05;
    localparam logic [4:0] PML_REG_CABLE_DIAG = 5'h1D;
    localparam logic [4:0] PML_REG_SPECIAL = 5'h1F;

    // basic control field positions
    localparam int PML_BC_FAR_LB = 14;
    localparam int PML_BC_FORCE100 = 13;
    localparam int PML_BC_AUTONEG_ENABLE_BIT = 12;
    localparam int PML_BC_POWER_DOWN = 11;
    localparam int PML_BC_AN_RESTART = 9;
    localparam int PML_BC_FULL_DUPLEX = 8;
    // basic status field positions
    localparam int PML_BS_AN_COMPLETE = 5;
    localparam int PML_BS_AN_CAPABLE = 3;
    localparam int PML_BS_LINK_UP = 2;
    localparam logic [15:0] PML_BS_FIXED = 16'h7800;
    // special control field position
    localparam int PML_SC_NEAR_LB = 1;
    // cable diagnostic start bit
    localparam int PML_CD_START = 15;
    // advertisement layout
    localparam logic [3:0] PML_ADV_ABILITY_RST = 4'hF;
    localparam logic [4:0] PML_ADV_SELECTOR = 5'h01;

    // switch-side register numbers
    localparam logic [7:0] PML_SW_GLOBAL_ADDR = 8'h0F;
    localparam logic [7:0] PML_SW_P1_CTRL_A = 8'h1A;
    localparam logic [7:0] PML_SW_P1_CTRL_B = 8'h1C;
    localparam logic [7:0] PML_SW_P1_CTRL_C = 8'h1D;
    localparam logic [7:0] PML_SW_P2_CTRL_A = 8'h2A;
    localparam logic [7:0] PML_SW_P2_CTRL_B = 8'h2C;
    localparam logic [7:0] PML_SW_P2_CTRL_C = 8'h2D;
    // switch-side field positions
    localparam int PML_SWA_NEAR_LB = 1;
    localparam int PML_SWB_AUTONEG_ENABLE_BIT = 7;
    localparam int PML_SWB_FORCE100 = 6;
    localparam int PML_SWB_FULL_DUPLEX = 5;
    localparam int PML_SWC_FAR_LB = 0;
    localparam int PML_SWC_POWER_DOWN = 3;
    localparam int PML_SWC_AN_RESTART = 5;
    localparam int PML_SWG_ADDR_LSB = 3;

    // reset values; base 1 gives the first phy address 1 and the second 2
    localparam logic [4:0] PML_PHY_BASE_RST = 5'h01;
    localparam logic PML_AUTONEG_ENABLE_BIT_RST = 1'b1;

    // received or transmitted nibble on one port
    typedef struct packed {
        logic valid;
        logic [3:0] nibble;
    } pml_line_t;

    // one decoded management frame
    typedef struct packed {
        logic wrStb;
        logic isRead;
        logic [4:0] phyAddr;
        logic [4:0] regAddr;
        logic [15:0] data;
    } pml_mgmt_req_t;

    // per-port controls handed to the phy
    typedef struct packed {
        logic force100;
        logic anEnable;
        logic powerDown;
        logic anRestart;
        logic fullDuplex;
        logic cableTest;
    } pml_phy_ctrl_t;

    typedef enum logic [2:0] {
        PML_ST_IDLE = 3'h0,
        PML_ST_START = 3'h1,
        PML_ST_HEAD = 3'h2,
        PML_ST_TURN = 3'h3,
        PML_ST_DATA = 3'h4
    } pml_frame_state_t;

endpackage

/* File: core/pml_mdio_frame.sv */
// serial management frame engine, sampled on rising management clock edges
`timescale 1ns/1ps
module pml_mdio_frame import pml_pkg::*; (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic mdcRise,
    input wire logic mdioBit,
    input wire logic addrHit,
    input wire logic [15:0] rdData,
    output pml_mgmt_req_t req,
    output logic mdioOut,
    output logic mdioOe
);
    pml_frame_state_t state_q;
    logic [5:0] ones_q;
    logic [4:0] cnt_q;
    logic [15:0] shift_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= PML_ST_IDLE;
            ones_q <= 6'h00;
            cnt_q <= 5'h00;
            shift_q <= 16'h0000;
            req <= '0;
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
        end else begin
            req.wrStb <= 1'b0;
            if (mdcRise) begin
                case (state_q)
                    PML_ST_IDLE: begin
                        if (mdioBit) begin
                            if (ones_q != 6'(PML_PREAMBLE_ONES)) ones_q <= ones_q + 6'h01;
                        end else begin
                            // a short preamble is ignored rather than guessed at
                            if (ones_q == 6'(PML_PREAMBLE_ONES)) state_q <= PML_ST_START;
                            ones_q <= 6'h00;
                        end
                    end
                    PML_ST_START: begin
                        state_q <= mdioBit ? PML_ST_HEAD : PML_ST_IDLE;
                        cnt_q <= 5'h00;
                    end
                    PML_ST_HEAD: begin
                        shift_q <= {shift_q[14:0], mdioBit};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'(PML_HEAD_BITS - 1)) begin
                            req.isRead <= shift_q[10:9] == PML_OP_READ;
                            req.phyAddr <= shift_q[8:4];
                            req.regAddr <= {shift_q[3:0], mdioBit};
                            state_q <= PML_ST_TURN;
                            cnt_q <= 5'h00;
                        end
                    end
                    PML_ST_TURN: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'h00) begin
                            // drive the second turnaround bit low only when addressed
                            if (req.isRead && addrHit) begin
                                mdioOe <= 1'b1;
                                mdioOut <= 1'b0;
                            end
                        end else begin
                            state_q <= PML_ST_DATA;
                            cnt_q <= 5'h00;
                            mdioOut <= rdData[15];
                            shift_q <= {rdData[14:0], 1'b0};
                        end
                    end
                    PML_ST_DATA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (req.isRead) begin
                            mdioOut <= shift_q[15];
                            shift_q <= {shift_q[14:0], 1'b0};
                        end else begin
                            shift_q <= {shift_q[14:0], mdioBit};
                        end
                        if (cnt_q == 5'(PML_DATA_BITS - 1)) begin
                            mdioOe <= 1'b0;
                            mdioOut <= 1'b0;
                            state_q <= PML_ST_IDLE;
                            if (!req.isRead) begin
                                req.wrStb <= 1'b1;
                                req.data <= {shift_q[14:0], mdioBit};
                            end
                        end
                    end
                    default: state_q <= PML_ST_IDLE;
                endcase
            end
        end
    end
endmodule // pml_mdio_frame

/* File: core/pml_phy_mgmt_regs.sv */
// per-phy management register view, switch-side mirrors and loopback paths
//
// Overview of operation
// R1: software sets both ports to 100 Mbps first
// R2: far-end: receive, turn at other port, retransmit
// R3: switch regs 29/45 bit 0 enable far-end
// R4: control bit 14 shares far-end enable state
// R5: port 1 far-end loops port 2 traffic
// R6: near-end: receive turned back at same port
// R7: switch regs 26/42 bit 1 enable near-end
// R8: special register bit 1 also enables near-end
// R9: phy addresses default to 1 and 2
// R10: global register 15 bits 7:3 reprogram addresses
// R11: only registers 0-5, 1D, 1F implemented
// R12: fixed meaning of each supported register
// R13: switch bus reaches mirrors by own map
// R14: control bit 12 autoneg enable, resets 1
// R15: control bit 9 restarts autoneg, resets 0
// R16: bits 13, 11, 8 speed, power, duplex
// R17: control bits 15, 10, 7 read zero
`timescale 1ns/1ps
module pml_phy_mgmt_regs import pml_pkg::*; #(
    // identifier words; values are arbitrary
    parameter logic [15:0] ID_HIGH = 16'h5A5A,
    parameter logic [15:0] ID_LOW = 16'hC3C0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic swWrEn,
    input wire logic [7:0] swAddr,
    input wire logic [7:0] swWrData,
    output logic [7:0] swRdData,
    input wire logic [1:0] linkUp,
    input wire logic [1:0] anDone,
    input pml_line_t rxLine [2],
    input pml_line_t macTx [2],
    output pml_line_t txLine [2],
    output pml_line_t macRx [2],
    output pml_phy_ctrl_t phyCtrl [2]
);
    // synchronisers for pins from outside the clock domain
    logic mdcMeta_q, mdcSync_q, mdcLast_q;
    logic mdioMeta_q, mdioSync_q;
    logic [1:0] linkMeta_q, linkSync_q;
    logic [1:0] anMeta_q, anSync_q;
    logic mdcRise;

    // per-port control state; loopback and basic control bits shared by both register spaces, advertisement and cable test by frames only
    logic [1:0] farLb_q;
    logic [1:0] nearLb_q;
    logic [1:0] force100_q;
    logic [1:0] anEnable_q;
    logic [1:0] powerDown_q;
    logic [1:0] anRestart_q;
    logic [1:0] fullDuplex_q;
    logic [1:0] cableTest_q;
    logic [3:0] advAbility_q [2];
    logic [4:0] phyBase_q;

    pml_mgmt_req_t req;
    logic addrHit;
    logic reqPort;
    logic [15:0] rdData;
    logic swPort;
    logic swHitA, swHitB, swHitC;
    logic mdioWr;

    pml_line_t loopStage_q [2];

    // pin synchronisers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mdcMeta_q <= 1'b0;
            mdcSync_q <= 1'b0;
            mdcLast_q <= 1'b0;
            mdioMeta_q <= 1'b1;
            mdioSync_q <= 1'b1;
        end else begin
            mdcMeta_q <= mdc;
            mdcSync_q <= mdcMeta_q;
            mdcLast_q <= mdcSync_q;
            mdioMeta_q <= mdioIn;
            mdioSync_q <= mdioMeta_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            linkMeta_q <= 2'h0;
            linkSync_q <= 2'h0;
            anMeta_q <= 2'h0;
            anSync_q <= 2'h0;
        end else begin
            linkMeta_q <= linkUp;
            linkSync_q <= linkMeta_q;
            anMeta_q <= anDone;
            anSync_q <= anMeta_q;
        end
    end

    // edge taken only from synchronised copies
    assign mdcRise = mdcSync_q & ~mdcLast_q;

    // address decoding
    // second phy sits one above the programmed base
    function automatic logic [4:0] phyAddrOf(input logic port, input logic [4:0] base);
        phyAddrOf = port ? 5'(base + 5'h01) : base;
    endfunction

    function automatic logic regSupported(input logic [4:0] ra);
        regSupported = (ra <= PML_REG_LP_ABILITY) || (ra == PML_REG_CABLE_DIAG)
            || (ra == PML_REG_SPECIAL);
    endfunction

    always_comb begin
        addrHit = 1'b0;
        reqPort = 1'b0;
        if (req.phyAddr == phyAddrOf(1'b0, phyBase_q)) begin // [R9] [R10]
            addrHit = 1'b1;
        end else if (req.phyAddr == phyAddrOf(1'b1, phyBase_q)) begin // [R9] [R10]
            addrHit = 1'b1;
            reqPort = 1'b1;
        end
    end

    assign mdioWr = req.wrStb && addrHit && regSupported(req.regAddr); // [R11]

    // switch-side numbers differ from the management numbering
    always_comb begin
        swPort = (swAddr == PML_SW_P2_CTRL_A) || (swAddr == PML_SW_P2_CTRL_B)
            || (swAddr == PML_SW_P2_CTRL_C); // [R13]
        swHitA = (swAddr == PML_SW_P1_CTRL_A) || (swAddr == PML_SW_P2_CTRL_A);
        swHitB = (swAddr == PML_SW_P1_CTRL_B) || (swAddr == PML_SW_P2_CTRL_B);
        swHitC = (swAddr == PML_SW_P1_CTRL_C) || (swAddr == PML_SW_P2_CTRL_C);
    end

    // management read view
    function automatic logic [15:0] basicControl(input logic p, input logic [1:0] far,
            input logic [1:0] f100, input logic [1:0] an, input logic [1:0] pd,
            input logic [1:0] rs, input logic [1:0] fd);
        logic [15:0] v;
        v = 16'h0000; // [R17]
        v[PML_BC_FAR_LB] = far[p]; // [R4]
        v[PML_BC_FORCE100] = f100[p]; // [R16]
        v[PML_BC_AUTONEG_ENABLE_BIT] = an[p]; // [R14]
        v[PML_BC_POWER_DOWN] = pd[p]; // [R16]
        v[PML_BC_AN_RESTART] = rs[p]; // [R15]
        v[PML_BC_FULL_DUPLEX] = fd[p]; // [R16]
        basicControl = v;
    endfunction

    always_comb begin
        rdData = 16'h0000;
        case (req.regAddr) // [R11] [R12]
            PML_REG_BASIC_CONTROL: begin
                rdData = basicControl(reqPort, farLb_q, force100_q, anEnable_q,
                    powerDown_q, anRestart_q, fullDuplex_q);
            end
            PML_REG_BASIC_STATUS: begin
                rdData = PML_BS_FIXED;
                rdData[PML_BS_AN_COMPLETE] = anSync_q[reqPort];
                rdData[PML_BS_AN_CAPABLE] = anEnable_q[reqPort];
                rdData[PML_BS_LINK_UP] = linkSync_q[reqPort];
            end
            PML_REG_ID_HIGH: rdData = ID_HIGH;
            PML_REG_ID_LOW: rdData = ID_LOW;
            PML_REG_AN_ADVERT: rdData = {7'h00, advAbility_q[reqPort], PML_ADV_SELECTOR};
            // partner ability is filled by the negotiation engine, not kept here
            PML_REG_LP_ABILITY: rdData = 16'h0000;
            PML_REG_CABLE_DIAG: rdData[PML_CD_START] = cableTest_q[reqPort];
            PML_REG_SPECIAL: rdData[PML_SC_NEAR_LB] = nearLb_q[reqPort]; // [R8]
            default: rdData = 16'h0000; // [R11]
        endcase
    end

    pml_mdio_frame u_frame (
        .mclk(mclk),
        .rstn(rstn),
        .mdcRise(mdcRise),
        .mdioBit(mdioSync_q),
        .addrHit(addrHit),
        .rdData(rdData),
        .req(req),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe)
    );

    // loopback enables; the management write is applied after the
    // switch-side write so a same-cycle collision keeps the frame value
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            farLb_q <= 2'h0;
            nearLb_q <= 2'h0;
        end else begin
            if (swWrEn && swHitC) farLb_q[swPort] <= swWrData[PML_SWC_FAR_LB]; // [R3]
            if (swWrEn && swHitA) nearLb_q[swPort] <= swWrData[PML_SWA_NEAR_LB]; // [R7]
            if (mdioWr && req.regAddr == PML_REG_BASIC_CONTROL) begin
                farLb_q[reqPort] <= req.data[PML_BC_FAR_LB]; // [R4]
            end
            if (mdioWr && req.regAddr == PML_REG_SPECIAL) begin
                nearLb_q[reqPort] <= req.data[PML_SC_NEAR_LB]; // [R8]
            end
        end
    end

    // basic control mirrors
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            force100_q <= 2'h0;
            anEnable_q <= {2{PML_AUTONEG_ENABLE_BIT_RST}}; // [R14]
            powerDown_q <= 2'h0;
            fullDuplex_q <= 2'h0;
        end else begin
            if (swWrEn && swHitB) begin
                anEnable_q[swPort] <= swWrData[PML_SWB_AUTONEG_ENABLE_BIT]; // [R14]
                force100_q[swPort] <= swWrData[PML_SWB_FORCE100]; // [R16]
                fullDuplex_q[swPort] <= swWrData[PML_SWB_FULL_DUPLEX]; // [R16]
            end
            if (swWrEn && swHitC) begin
                powerDown_q[swPort] <= swWrData[PML_SWC_POWER_DOWN]; // [R16]
            end
            if (mdioWr && req.regAddr == PML_REG_BASIC_CONTROL) begin
                anEnable_q[reqPort] <= req.data[PML_BC_AUTONEG_ENABLE_BIT]; // [R14]
                force100_q[reqPort] <= req.data[PML_BC_FORCE100]; // [R16]
                powerDown_q[reqPort] <= req.data[PML_BC_POWER_DOWN]; // [R16]
                fullDuplex_q[reqPort] <= req.data[PML_BC_FULL_DUPLEX]; // [R16]
            end
        end
    end

    // restart is a command: it holds for one cycle and then clears itself
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            anRestart_q <= 2'h0; // [R15]
        end else begin
            anRestart_q <= 2'h0;
            if (swWrEn && swHitC) begin
                anRestart_q[swPort] <= swWrData[PML_SWC_AN_RESTART]; // [R15]
            end
            if (mdioWr && req.regAddr == PML_REG_BASIC_CONTROL) begin
                anRestart_q[reqPort] <= req.data[PML_BC_AN_RESTART]; // [R15]
            end
        end
    end

    // address base, advertisement and cable test
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            phyBase_q <= PML_PHY_BASE_RST; // [R9]
        end else if (swWrEn && swAddr == PML_SW_GLOBAL_ADDR) begin
            phyBase_q <= swWrData[PML_SWG_ADDR_LSB +: 5]; // [R10]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            advAbility_q[0] <= PML_ADV_ABILITY_RST;
            advAbility_q[1] <= PML_ADV_ABILITY_RST;
            cableTest_q <= 2'h0;
        end else if (mdioWr) begin
            if (req.regAddr == PML_REG_AN_ADVERT) begin
                advAbility_q[reqPort] <= req.data[8:5]; // [R12]
            end
            if (req.regAddr == PML_REG_CABLE_DIAG) begin
                cableTest_q[reqPort] <= req.data[PML_CD_START]; // [R12]
            end
        end
    end

    // switch-side read port, one cycle latency
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            swRdData <= 8'h00;
        end else begin
            swRdData <= 8'h00;
            if (swAddr == PML_SW_GLOBAL_ADDR) begin
                swRdData[PML_SWG_ADDR_LSB +: 5] <= phyBase_q; // [R10]
            end else if (swHitA) begin
                swRdData[PML_SWA_NEAR_LB] <= nearLb_q[swPort]; // [R7]
            end else if (swHitB) begin
                swRdData[PML_SWB_AUTONEG_ENABLE_BIT] <= anEnable_q[swPort];
                swRdData[PML_SWB_FORCE100] <= force100_q[swPort];
                swRdData[PML_SWB_FULL_DUPLEX] <= fullDuplex_q[swPort];
            end else if (swHitC) begin
                swRdData[PML_SWC_FAR_LB] <= farLb_q[swPort]; // [R3]
                swRdData[PML_SWC_POWER_DOWN] <= powerDown_q[swPort];
                swRdData[PML_SWC_AN_RESTART] <= anRestart_q[swPort];
            end
        end
    end

    // loopback datapath
    // loopStage[o] models the turn at port o's PMD/PMA for traffic from
    // the other port; it adds one cycle, which a looped stream tolerates
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            loopStage_q[0] <= '0;
            loopStage_q[1] <= '0;
        end else begin
            loopStage_q[0] <= farLb_q[0] ? rxLine[1] : '0; // [R5]
            loopStage_q[1] <= farLb_q[1] ? rxLine[0] : '0; // [R5]
        end
    end

    // speed is not checked: looping at 10 Mbps is left to software
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            txLine[0] <= '0;
            txLine[1] <= '0;
            macRx[0] <= '0;
            macRx[1] <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (powerDown_q[p]) begin
                    txLine[p] <= '0;
                    macRx[p] <= '0;
                end else if (nearLb_q[p]) begin
                    txLine[p] <= rxLine[p]; // [R6]
                    macRx[p] <= '0;
                end else if (farLb_q[1 - p]) begin
                    txLine[p] <= loopStage_q[1 - p]; // [R2] [R5]
                    macRx[p] <= '0;
                end else begin
                    txLine[p] <= macTx[p];
                    macRx[p] <= rxLine[p];
                end
            end
        end
    end

    // controls to the phys, registered copies
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            phyCtrl[0] <= '0;
            phyCtrl[1] <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                phyCtrl[p].force100 <= force100_q[p];
                phyCtrl[p].anEnable <= anEnable_q[p];
                phyCtrl[p].powerDown <= powerDown_q[p];
                phyCtrl[p].anRestart <= anRestart_q[p];
                phyCtrl[p].fullDuplex <= fullDuplex_q[p];
                phyCtrl[p].cableTest <= cableTest_q[p];
            end
        end
    end

endmodule // pml_phy_mgmt_regs

/* File: test/pml_station.sv */
// station management controller model for the serial management pins
`timescale 1ns/1ps
module pml_station import pml_pkg::*; (
    input wire logic mclk,
    input wire logic mdioOut,
    input wire logic mdioOe,
    output logic mdc,
    output logic mdioLine
);
    logic drv = 1'b1;
    logic stOe = 1'b0;
    initial mdc = 1'b0;
    // released line floats to the pull-up, never to a stale bit
    assign mdioLine = mdioOe ? mdioOut : (stOe ? drv : 1'b1);
    // mdc stands low between frames; 11 mclk per bit keeps it near 10 MHz
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] wd, output logic [15:0] rdat);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h1, rd ? PML_OP_READ : PML_OP_WRITE, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            @(negedge mclk);
            stOe = !(rd && i < 18);
            drv = f[i];
            repeat (5) @(negedge mclk);
            if (i < 16) rdat[i] = mdioLine;
            mdc = 1'b1;
            repeat (5) @(negedge mclk);
            mdc = 1'b0;
        end
        stOe = 1'b0;
    endtask
endmodule // pml_station

/* File: test/pml_phy_mgmt_regs_sva.sv */
// assertions on the switch port, phy controls and loopback paths
`timescale 1ns/1ps
module pml_phy_mgmt_regs_sva import pml_pkg::*; (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic swWrEn,
    input wire logic [7:0] swAddr,
    input wire logic [7:0] swWrData,
    input wire logic [7:0] swRdData,
    input pml_line_t rxLine [2],
    input pml_line_t txLine [2],
    input pml_phy_ctrl_t phyCtrl [2]
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence farOn_s;
        swWrEn && swAddr == 8'h1D && swWrData == 8'h01 ##1 !swWrEn [*4];
    endsequence
    sequence nearOn_s;
        swWrEn && swAddr == 8'h2A && swWrData == 8'h02 ##1 !swWrEn [*3];
    endsequence
    sequence rdBack_s(a);
        swWrEn && swAddr == a ##1 swAddr == a;
    endsequence
    unmapped_read_a: assert property (
        !(swAddr inside {8'h0F, 8'h1A, 8'h1C, 8'h1D, 8'h2A, 8'h2C, 8'h2D}) |=> swRdData == 8'h00)
        else $error("unmapped read");
    far_readback_a: assert property (
        rdBack_s(8'h1D) |=> swRdData == ($past(swWrData, 2) & 8'h29)) else $error("far readback");
    near_readback_a: assert property (
        rdBack_s(8'h2A) |=> swRdData == ($past(swWrData, 2) & 8'h02)) else $error("near readback");
    autoneg_enable_bit_a: assert property (
        swWrEn && swAddr == 8'h1C |-> ##2 phyCtrl[0].anEnable == $past(swWrData[7], 2))
        else $error("autoneg enable");
    force_speed_a: assert property (
        swWrEn && swAddr == 8'h2C |-> ##2 phyCtrl[1].force100 == $past(swWrData[6], 2))
        else $error("speed select");
    restart_pulse_a: assert property (
        swWrEn && swAddr == 8'h2D && swWrData[5] |-> ##2 phyCtrl[1].anRestart
        ##1 !phyCtrl[1].anRestart) else $error("restart pulse");
    far_loop_a: assert property (
        farOn_s |-> txLine[1] == $past(rxLine[1], 2)) else $error("far loop path");
    near_loop_a: assert property (
        nearOn_s |-> txLine[1] == $past(rxLine[1])) else $error("near loop path");
endmodule // pml_phy_mgmt_regs_sva

/* File: test/pml_phy_mgmt_regs_tb.sv */
// self-checking bench for the phy management register bank
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module pml_phy_mgmt_regs_tb import pml_pkg::*; ;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic swWrEn = 1'b0;
    logic [7:0] swAddr = 8'h00;
    logic [7:0] swWrData = 8'h00;
    logic [1:0] linkUp = 2'h1;
    logic [1:0] anDone = 2'h2;
    logic [3:0] pat = 4'h0;
    logic mdc, mdioIn, mdioOut, mdioOe;
    logic [7:0] swRdData;
    logic [15:0] rd;
    pml_line_t rxLine [2];
    pml_line_t macTx [2];
    pml_line_t txLine [2];
    pml_line_t macRx [2];
    int num_errors = 0;
    int num_checks = 0;
    always #5 mclk = ~mclk;
    always @(negedge mclk) pat <= pat + 4'h3;
    assign rxLine[0] = '{1'b1, pat};
    assign rxLine[1] = '{1'b1, ~pat};
    assign macTx[0] = '{1'b1, pat ^ 4'h5};
    assign macTx[1] = '{1'b0, pat ^ 4'hA};
    pml_station st (.mclk(mclk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc), .mdioLine(mdioIn));
    pml_phy_mgmt_regs dut (.mclk(mclk), .rstn(rstn), .mdc(mdc), .mdioIn(mdioIn),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .swWrEn(swWrEn), .swAddr(swAddr),
        .swWrData(swWrData), .swRdData(swRdData), .linkUp(linkUp), .anDone(anDone),
        .rxLine(rxLine), .macTx(macTx), .txLine(txLine), .macRx(macRx), .phyCtrl());
    task automatic sw(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        swAddr = a;
        swWrData = d;
        swWrEn = 1'b1;
        @(negedge mclk);
        swWrEn = 1'b0;
    endtask
    task automatic swrd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        swAddr = a;
        @(negedge mclk);
        `CHK(swRdData, e)
    endtask
    task automatic mr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
        st.frame(1'b1, pa, ra, 16'h0000, rd);
        `CHK(rd, e)
    endtask
    task automatic mw(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        st.frame(1'b0, pa, ra, d, rd);
        repeat (4) @(negedge mclk);
    endtask
    task automatic t_reset();
        mr(5'h01, 5'h00, 16'h1000);
        mr(5'h02, 5'h01, 16'h7828);
        mr(5'h01, 5'h01, 16'h780C);
        mr(5'h01, 5'h04, 16'h01E1);
        mr(5'h01, 5'h06, 16'h0000);
        mr(5'h02, 5'h1E, 16'h0000);
        swrd(8'h1C, 8'h80);
        swrd(8'h10, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_ctrl();
        mw(5'h01, 5'h00, 16'hFFFF);
        mr(5'h01, 5'h00, 16'h7900);
        swrd(8'h1D, 8'h09);
        swrd(8'h1C, 8'hE0);
        mw(5'h01, 5'h00, 16'h2000);
        sw(8'h1C, 8'h40);
        sw(8'h2C, 8'h40);
        sw(8'h2D, 8'h20);
        swrd(8'h2D, 8'h00);
        $display("control test done");
    endtask
    task automatic t_loop();
        mw(5'h02, 5'h1F, 16'h0002);
        swrd(8'h2A, 8'h02);
        `CHK(macRx[1], 5'h00)
        sw(8'h2A, 8'h00);
        sw(8'h2A, 8'h02);
        swrd(8'h2A, 8'h02);
        sw(8'h2A, 8'h00);
        sw(8'h1D, 8'h01);
        mr(5'h01, 5'h00, 16'h6000);
        sw(8'h1D, 8'h00);
        $display("loopback test done");
    endtask
    task automatic t_addr();
        sw(8'h0F, 8'h28);
        swrd(8'h0F, 8'h28);
        mr(5'h05, 5'h00, 16'h2000);
        mr(5'h06, 5'h00, 16'h2000);
        mr(5'h01, 5'h00, 16'hFFFF);
        $display("address test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_ctrl();
        t_loop();
        t_addr();
        finish_test();
    end
    // 14 frames of about 700 cycles; ample margin
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
endmodule // pml_phy_mgmt_regs_tb
bind pml_phy_mgmt_regs pml_phy_mgmt_regs_sva chk (.mclk(mclk), .rstn(rstn), .swWrEn(swWrEn),
    .swAddr(swAddr), .swWrData(swWrData), .swRdData(swRdData), .rxLine(rxLine),
    .txLine(txLine), .phyCtrl(phyCtrl));
